// ---- hw/dtfs_pkg.sv ----
// Purpose: Shared constants and types for the drive terminal function select.
// Assumes: APB slave, 32-bit data, one word per register.
// Notes: Selection codes are decimal values held in 16-bit fields.
package dtfs_pkg;

	localparam logic [7:0] ADDR_SEL_DO1 = 8'h00;
	localparam logic [7:0] ADDR_SEL_DO2 = 8'h04;
	localparam logic [7:0] ADDR_SEL_DO3 = 8'h08;
	localparam logic [7:0] ADDR_SEL_ALM = 8'h0C;
	localparam logic [7:0] ADDR_CTRL = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_DUTY = 8'h18;

	localparam logic [15:0] RST_SEL_DO1 = 16'h0000;
	localparam logic [15:0] RST_SEL_DO2 = 16'h0001;
	localparam logic [15:0] RST_SEL_DO3 = 16'h0002;
	localparam logic [15:0] RST_SEL_ALM = 16'h0063;
	localparam logic [1:0] RST_CTRL = 2'h2;
	localparam logic [15:0] CODE_NONE = 16'h270F;
	localparam logic [15:0] NEG_OFFSET = 16'h0064;
	localparam logic [15:0] NEG_LIMIT = 16'h00C8;

	// Status function codes (positive polarity).
	localparam logic [6:0] FN_RUN = 7'h00;
	localparam logic [6:0] FN_SU = 7'h01;
	localparam logic [6:0] FN_IPF = 7'h02;
	localparam logic [6:0] FN_OL = 7'h03;
	localparam logic [6:0] FN_FU = 7'h04;
	localparam logic [6:0] FN_FU2 = 7'h05;
	localparam logic [6:0] FN_FU3 = 7'h06;
	localparam logic [6:0] FN_RBP = 7'h07;
	localparam logic [6:0] FN_THP = 7'h08;
	localparam logic [6:0] FN_PU = 7'h0A;
	localparam logic [6:0] FN_RY = 7'h0B;
	localparam logic [6:0] FN_Y12 = 7'h0C;
	localparam logic [6:0] FN_FLUX = 7'h27;
	localparam logic [6:0] FN_ALARM = 7'h63;

	// Prealarm thresholds are 85 percent of the limit.
	localparam int PREALARM_PCT = 85;

	// Control bit positions in the control register.
	localparam int CTRL_VF = 0;
	localparam int CTRL_TUNE_EN = 1;

	// Control kinds.
	typedef enum logic [1:0]
	{
		KIND_SPEED = 2'b00,
		KIND_TORQUE = 2'b01,
		KIND_POSITION = 2'b10
	} dtfs_kind_t;

	// Tuning sequencer states.
	typedef enum logic [1:0]
	{
		TS_IDLE = 2'b00,
		TS_TUNE = 2'b01,
		TS_DONE = 2'b10
	} dtfs_tstate_t;

	// Internal motor-control status, sampled on sys_clk.
	typedef struct packed
	{
		logic at_target_speed_status;
		logic speed_detect_status;
		logic second_speed_detect_status;
		logic third_speed_detect_status;
		logic supply_fail;
		logic undervoltage;
		logic restriction_active;
		logic stall_active;
		logic dc_brake;
		logic zero_speed_ctrl;
		logic servo_lock;
		logic above_start_speed;
		logic cmd_below_start;
		logic residual_flux;
		logic panel_mode_flag;
		logic ready_to_start_flag;
		logic current_detect_flag;
		logic fault_alarm_flag;
		logic minor_alarm_flag;
		logic upkeep_timer_flag;
		logic tune_finished;
	} dtfs_stat_t;

	// Terminal input functions after assignment.
	typedef struct packed
	{
		logic forward_start_in;
		logic reverse_start_in;
		logic pre_excite_in;
		logic tuning_request_in;
		logic prop_only_select_in;
		logic bias_select_a_in;
		logic bias_select_b_in;
		logic control_kind_change_in;
		logic torque_limit_level_in;
	} dtfs_inp_t;

endpackage

// ---- hw/dtfs_top.sv ----
// Contract
// - Each output terminal has its own selector.
// - Code n+100 is code n inverted.
// - Prop-only input high selects P outside V/F, else PI.
// - Tuning request while stopped starts tuning.
// - Pre-excite plus slow start also tunes.
// - Residual flux flag follows remaining flux.
// - Tuning request ignored while flux remains.
// - Start inputs ignored until tuning completes or V/F ends it.
// - During tuning only listed outputs and the alarm relay update.
// - No tuning under V/F control.
// - Running follows start, with V/F and brake exceptions.
// - Power loss on supply fail or undervoltage.
// - Overload on restriction outside V/F, or stall under V/F.
// - Regen prealarm at 85 percent duty.
// - Thermal prealarm at 85 percent level.
// - Two bias inputs pick torque bias.
// - Kind-change input switches control kind.
// - Limit-level input selects second limit.
//
// Purpose: Routes drive status to output terminals, decodes input functions.
// Assumes: Terminal inputs are already assigned; status is synchronous.
// Notes: Codes outside the accepted set are refused and the old value kept.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module dtfs_top
#(
	parameter int ACC_W = 16
)
(
	// Clock, reset and enable.
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Drive status and accumulators.
	input wire dtfs_pkg::dtfs_stat_t stat,
	input wire logic [ACC_W-1:0] regen_duty_acc,
	input wire logic [ACC_W-1:0] thermal_acc,
	input wire logic [ACC_W-1:0] thermal_trip,
	// Terminal inputs from pins.
	input wire dtfs_pkg::dtfs_inp_t pins,
	// Output terminals.
	output logic digital_out_one,
	output logic digital_out_two,
	output logic digital_out_three,
	output logic alarm_relay_terminal,
	// Control outputs to the motor-control core.
	output logic residual_flux_flag,
	output logic tune_active,
	output logic start_fwd,
	output logic start_rev,
	output logic pre_excite,
	output logic prop_only,
	output logic [1:0] torque_bias_sel,
	output logic [1:0] control_kind,
	output logic second_limit
);

	if (ACC_W < 8 || ACC_W > 24)
	begin : g_bad_acc_w
		$error("ACC_W must lie between 8 and 24");
	end

	logic rst_a_ff;
	logic rst_b_ff;
	logic rst_n;
	dtfs_pkg::dtfs_inp_t in_s1_ff;
	dtfs_pkg::dtfs_inp_t in_s2_ff;
	dtfs_pkg::dtfs_inp_t in_s3_ff;
	dtfs_pkg::dtfs_inp_t in_ff;
	logic [15:0] sel_ff [4];
	logic [1:0] ctrl_ff;
	logic [ACC_W-1:0] duty_ff;
	dtfs_pkg::dtfs_tstate_t ts_ff;
	dtfs_pkg::dtfs_tstate_t nxt_ts;
	logic [127:0] fn;
	logic [3:0] term;
	logic [3:0] term_ff;
	logic kind_in_d_ff;
	logic vf;
	logic tuning;
	logic start_cmd;
	logic start_block;
	logic wr;
	logic rd;
	logic code_ok;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_a_ff <= 1'b0;
			rst_b_ff <= 1'b0;
		end
		else
		begin
			rst_a_ff <= 1'b1;
			rst_b_ff <= rst_a_ff;
		end
	end
	assign rst_n = rst_b_ff;

	// Three-stage pin sampling; a change counts once stages two and three agree.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			in_s1_ff <= '0;
			in_s2_ff <= '0;
			in_s3_ff <= '0;
			in_ff <= '0;
		end
		else if (clk_en)
		begin
			in_s1_ff <= pins;
			in_s2_ff <= in_s1_ff;
			in_s3_ff <= in_s2_ff;
			for (int i = 0; i < $bits(in_ff); i++)
				if (in_s2_ff[i] == in_s3_ff[i])
					in_ff[i] <= in_s3_ff[i];
		end
	end

	assign vf = ctrl_ff[dtfs_pkg::CTRL_VF];
	assign tuning = (ts_ff == dtfs_pkg::TS_TUNE);
	assign start_cmd = in_ff.forward_start_in | in_ff.reverse_start_in;
	// Starts are held back in the cycle that enters tuning as well.
	assign start_block = tuning || (nxt_ts == dtfs_pkg::TS_TUNE);

	// APB: zero-wait, every access made while clk_en is high completes in its first access cycle.
	assign wr = psel & penable & pwrite & clk_en;
	assign rd = psel & ~penable & ~pwrite;

	// Accepted codes: 0..99, 100..199 and 9999.
	assign code_ok = (pwdata[15:0] < dtfs_pkg::NEG_LIMIT) ||
		(pwdata[15:0] == dtfs_pkg::CODE_NONE);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel_ff[0] <= dtfs_pkg::RST_SEL_DO1;
			sel_ff[1] <= dtfs_pkg::RST_SEL_DO2;
			sel_ff[2] <= dtfs_pkg::RST_SEL_DO3;
			sel_ff[3] <= dtfs_pkg::RST_SEL_ALM;
			ctrl_ff <= dtfs_pkg::RST_CTRL;
			duty_ff <= '1;
		end
		else if (wr)
		begin
			case (paddr)
				dtfs_pkg::ADDR_SEL_DO1:
					if (code_ok) sel_ff[0] <= pwdata[15:0];
				dtfs_pkg::ADDR_SEL_DO2:
					if (code_ok) sel_ff[1] <= pwdata[15:0];
				dtfs_pkg::ADDR_SEL_DO3:
					if (code_ok) sel_ff[2] <= pwdata[15:0];
				dtfs_pkg::ADDR_SEL_ALM:
					if (code_ok) sel_ff[3] <= pwdata[15:0];
				dtfs_pkg::ADDR_CTRL:
					ctrl_ff <= pwdata[1:0];
				dtfs_pkg::ADDR_DUTY:
					duty_ff <= pwdata[ACC_W-1:0];
				default:
					ctrl_ff <= ctrl_ff;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready <= rd | (psel & ~penable);
			pslverr <= 1'b0;
			if (psel & ~penable)
			begin
				pslverr <= pwrite && (paddr == dtfs_pkg::ADDR_SEL_DO1 ||
					paddr == dtfs_pkg::ADDR_SEL_DO2 ||
					paddr == dtfs_pkg::ADDR_SEL_DO3 ||
					paddr == dtfs_pkg::ADDR_SEL_ALM) && !code_ok;
				case (paddr)
					dtfs_pkg::ADDR_SEL_DO1: prdata <= {16'h0000, sel_ff[0]};
					dtfs_pkg::ADDR_SEL_DO2: prdata <= {16'h0000, sel_ff[1]};
					dtfs_pkg::ADDR_SEL_DO3: prdata <= {16'h0000, sel_ff[2]};
					dtfs_pkg::ADDR_SEL_ALM: prdata <= {16'h0000, sel_ff[3]};
					dtfs_pkg::ADDR_CTRL: prdata <= {30'h0, ctrl_ff};
					dtfs_pkg::ADDR_STATUS:
						prdata <= {26'h0, ts_ff, term_ff};
					dtfs_pkg::ADDR_DUTY:
						prdata <= {{(32-ACC_W){1'b0}}, duty_ff};
					default:
					begin
						prdata <= 32'h00000000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// Tuning sequencer.
	always_comb
	begin
		nxt_ts = ts_ff;
		case (ts_ff)
			dtfs_pkg::TS_IDLE:
				if (!vf && ctrl_ff[dtfs_pkg::CTRL_TUNE_EN] &&
					!stat.residual_flux &&
					((in_ff.tuning_request_in && !start_cmd) ||
					(in_ff.pre_excite_in && start_cmd &&
					stat.cmd_below_start)))
					nxt_ts = dtfs_pkg::TS_TUNE;
			dtfs_pkg::TS_TUNE:
				if (vf)
					nxt_ts = dtfs_pkg::TS_IDLE;
				else if (stat.tune_finished)
					nxt_ts = dtfs_pkg::TS_DONE;
			dtfs_pkg::TS_DONE:
				if (!in_ff.tuning_request_in && !start_cmd)
					nxt_ts = dtfs_pkg::TS_IDLE;
			default:
				nxt_ts = dtfs_pkg::TS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ts_ff <= dtfs_pkg::TS_IDLE;
		else if (clk_en)
			ts_ff <= nxt_ts;
	end

	// Status function vector, indexed by positive code.
	always_comb
	begin
		fn = '0;
		fn[dtfs_pkg::FN_RUN] = start_cmd && !stat.dc_brake &&
			!stat.zero_speed_ctrl && !stat.servo_lock &&
			(!vf || stat.above_start_speed);
		fn[dtfs_pkg::FN_SU] = stat.at_target_speed_status;
		fn[dtfs_pkg::FN_IPF] = stat.supply_fail | stat.undervoltage;
		fn[dtfs_pkg::FN_OL] = vf ? stat.stall_active :
			stat.restriction_active;
		fn[dtfs_pkg::FN_FU] = stat.speed_detect_status;
		fn[dtfs_pkg::FN_FU2] = stat.second_speed_detect_status;
		fn[dtfs_pkg::FN_FU3] = stat.third_speed_detect_status;
		fn[dtfs_pkg::FN_RBP] = (32'(regen_duty_acc) * 100) >=
			(32'(duty_ff) * dtfs_pkg::PREALARM_PCT);
		fn[dtfs_pkg::FN_THP] = (32'(thermal_acc) * 100) >=
			(32'(thermal_trip) * dtfs_pkg::PREALARM_PCT);
		fn[dtfs_pkg::FN_PU] = stat.panel_mode_flag;
		fn[dtfs_pkg::FN_RY] = stat.ready_to_start_flag;
		fn[dtfs_pkg::FN_Y12] = stat.current_detect_flag;
		fn[dtfs_pkg::FN_FLUX] = stat.residual_flux;
		fn[dtfs_pkg::FN_ALARM] = stat.fault_alarm_flag;
	end

	// Codes that stay live during tuning.
	function automatic logic live_in_tune(input logic [6:0] c);
		live_in_tune = (c == dtfs_pkg::FN_IPF) || (c == dtfs_pkg::FN_THP) ||
			(c == dtfs_pkg::FN_PU) || (c == dtfs_pkg::FN_RY) ||
			(c == dtfs_pkg::FN_Y12) || (c == dtfs_pkg::FN_ALARM);
	endfunction

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_term
			logic neg;
			logic [6:0] code;
			logic none;
			assign none = (sel_ff[g] == dtfs_pkg::CODE_NONE);
			assign neg = (sel_ff[g] >= dtfs_pkg::NEG_OFFSET) && !none;
			assign code = neg ? 7'(sel_ff[g] - dtfs_pkg::NEG_OFFSET) :
				sel_ff[g][6:0];
			// Alarm relay terminal always stays live during tuning.
			assign term[g] = none ? 1'b0 :
				(tuning && g != 3 && !live_in_tune(code)) ? term_ff[g] :
				(fn[code] ^ neg);
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			term_ff <= 4'h0;
			residual_flux_flag <= 1'b0;
			tune_active <= 1'b0;
		end
		else if (clk_en)
		begin
			term_ff <= term;
			residual_flux_flag <= stat.residual_flux;
			tune_active <= (nxt_ts == dtfs_pkg::TS_TUNE);
		end
	end
	assign digital_out_one = term_ff[0];
	assign digital_out_two = term_ff[1];
	assign digital_out_three = term_ff[2];
	assign alarm_relay_terminal = term_ff[3];

	// Input functions towards the control core.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			start_fwd <= 1'b0;
			start_rev <= 1'b0;
			pre_excite <= 1'b0;
			prop_only <= 1'b0;
			torque_bias_sel <= 2'h0;
			control_kind <= dtfs_pkg::KIND_SPEED;
			second_limit <= 1'b0;
			kind_in_d_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			start_fwd <= in_ff.forward_start_in && !start_block;
			start_rev <= in_ff.reverse_start_in && !start_block;
			pre_excite <= in_ff.pre_excite_in && !start_block;
			prop_only <= !vf && in_ff.prop_only_select_in;
			torque_bias_sel <= {in_ff.bias_select_b_in,
				in_ff.bias_select_a_in};
			second_limit <= in_ff.torque_limit_level_in;
			kind_in_d_ff <= in_ff.control_kind_change_in;
			if (in_ff.control_kind_change_in != kind_in_d_ff)
				control_kind <= in_ff.control_kind_change_in ?
					dtfs_pkg::KIND_TORQUE : dtfs_pkg::KIND_SPEED;
		end
	end

	property p_sel_reject;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr && paddr == dtfs_pkg::ADDR_SEL_DO1 && !code_ok) |=>
			$stable(sel_ff[0]);
	endproperty
	a_sel_reject: assert property (p_sel_reject)
		else $error("Refused code was stored");

	property p_no_start_tune;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && tuning) |=> !start_fwd && !start_rev && !pre_excite;
	endproperty
	a_no_start_tune: assert property (p_no_start_tune)
		else $error("Start passed during tuning");

	property p_vf_no_tune;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && vf && !tuning) |=> !tuning;
	endproperty
	a_vf_no_tune: assert property (p_vf_no_tune)
		else $error("Tuning began under V/F");

	property p_flux_block;
		@(posedge sys_clk) disable iff (!rst_n)
		(ts_ff == dtfs_pkg::TS_IDLE && stat.residual_flux) |=> !tuning;
	endproperty
	a_flux_block: assert property (p_flux_block)
		else $error("Tuning began with residual flux");

	property p_polarity;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && !tuning && sel_ff[1] == 16'h0066) |=>
			(digital_out_two == !$past(fn[dtfs_pkg::FN_IPF]));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("Negative code not inverted");

	property p_ipf;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && !tuning && sel_ff[2] == 16'h0002 && stat.undervoltage)
			|=> digital_out_three;
	endproperty
	a_ipf: assert property (p_ipf)
		else $error("Power loss not shown");

	property p_freeze;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && tuning && sel_ff[0] == 16'h0001) |=>
			$stable(digital_out_one);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("Frozen output changed during tuning");

	property p_prop;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && vf) |=> !prop_only;
	endproperty
	a_prop: assert property (p_prop)
		else $error("P-only selected outside vector control");

endmodule

// ---- testbench/dtfs_wiring.sv ----
// Purpose: External wiring that drives the drive's terminal inputs.
// Assumes: Requested levels change just after a rising edge.
// Notes: Relay contacts settle one clock after the request.
`timescale 1ns/1ns
module dtfs_wiring
(
	// Clock.
	input wire logic sys_clk,
	// Requested and applied terminal levels.
	input wire dtfs_pkg::dtfs_inp_t want,
	output dtfs_pkg::dtfs_inp_t pins
);
	always_ff @(posedge sys_clk)
	begin
		pins <= want;
	end
endmodule

// ---- testbench/drive_terminal_function_select_test.sv ----
// Purpose: Self-checking bench for the terminal function select block.
// Assumes: APB answers in the first access cycle.
// Notes: Random codes and status levels come from a fixed seed.
`timescale 1ns/1ns
module drive_terminal_function_select_test;
	logic sys_clk = 0, resetn = 0, clk_en = 1;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, vf;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	dtfs_pkg::dtfs_stat_t stat = '0, s;
	dtfs_pkg::dtfs_inp_t want = '0, pins, p;
	logic [15:0] regen_duty_acc = '0, thermal_acc = '0;
	logic [15:0] thermal_trip = 16'h03E8;
	logic digital_out_one, digital_out_two, digital_out_three;
	logic alarm_relay_terminal, residual_flux_flag, tune_active;
	logic start_fwd, start_rev, pre_excite, prop_only, second_limit;
	logic [1:0] torque_bias_sel, control_kind;
	logic [7:0] adr [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
	logic [15:0] rst [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0063};
	logic [15:0] codes [14] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
		16'h0004,
		16'h0005, 16'h0006, 16'h0007, 16'h0008, 16'h000A, 16'h000B,
		16'h000C, 16'h0027, 16'h0063};
	logic [15:0] cd [4];
	logic [3:0] term;
	int failures = 0, total_checks = 0;

	always #25 sys_clk = ~sys_clk;

	dtfs_wiring u_dtfs_wiring (.sys_clk(sys_clk), .want(want), .pins(pins));

	dtfs_top u_dtfs_top (.sys_clk(sys_clk), .resetn(resetn),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stat(stat), .regen_duty_acc(regen_duty_acc),
		.thermal_acc(thermal_acc), .thermal_trip(thermal_trip),
		.pins(pins), .digital_out_one(digital_out_one),
		.digital_out_two(digital_out_two),
		.digital_out_three(digital_out_three),
		.alarm_relay_terminal(alarm_relay_terminal),
		.residual_flux_flag(residual_flux_flag),
		.tune_active(tune_active), .start_fwd(start_fwd),
		.start_rev(start_rev), .pre_excite(pre_excite),
		.prop_only(prop_only), .torque_bias_sel(torque_bias_sel),
		.control_kind(control_kind), .second_limit(second_limit));

	task summarize();
		if (failures == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (pready !== 1'b1)
		begin
			failures++;
			summarize();
		end
	endtask

	task wait_tune(input logic lvl);
		int n;
		for (n = 0; n < 30 && tune_active !== lvl; n++)
			@(posedge sys_clk);
		chk(tune_active, lvl);
		if (tune_active !== lvl)
			summarize();
	endtask

	// Expected terminal level for a selection code and status snapshot.
	function automatic logic fn_val(input logic [15:0] c,
		input dtfs_pkg::dtfs_stat_t t, input logic v, input logic th,
		input logic rg, input logic st);
		logic neg;
		logic [15:0] b;
		logic r;
		neg = c >= 16'h0064;
		b = neg ? c - 16'h0064 : c;
		case (b)
			16'h0000: r = st && !t.dc_brake && !t.zero_speed_ctrl &&
				!t.servo_lock && (!v || t.above_start_speed);
			16'h0001: r = t.at_target_speed_status;
			16'h0002: r = t.supply_fail | t.undervoltage;
			16'h0003: r = v ? t.stall_active : t.restriction_active;
			16'h0004: r = t.speed_detect_status;
			16'h0005: r = t.second_speed_detect_status;
			16'h0006: r = t.third_speed_detect_status;
			16'h0007: r = rg;
			16'h0008: r = th;
			16'h000A: r = t.panel_mode_flag;
			16'h000B: r = t.ready_to_start_flag;
			16'h000C: r = t.current_detect_flag;
			16'h0027: r = t.residual_flux;
			16'h0063: r = t.fault_alarm_flag;
			default: r = 1'b0;
		endcase
		return neg ? ~r : r;
	endfunction

	initial
	begin
		void'($urandom(32'h57B8B079));
		repeat (3) @(posedge sys_clk);
		resetn <= 1;
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 4; i++)
		begin
			apb(0, adr[i], 32'h0);
			chk(rd, {16'h0000, rst[i]});
		end
		apb(0, dtfs_pkg::ADDR_CTRL, 32'h0);
		chk(rd, 32'h0000_0002);
		apb(1, adr[0], 32'h0000_00C8);
		chk(er, 1);
		apb(1, adr[0], 32'h0000_270F);
		chk(er, 0);
		apb(1, adr[0], 32'h0000_270E);
		chk(er, 1);
		apb(0, adr[0], 32'h0);
		chk(rd, 32'h0000_270F);
		apb(0, 8'h40, 32'h0);
		chk(er, 1);
		chk(rd, 32'h0000_0000);
		apb(1, dtfs_pkg::ADDR_DUTY, 32'h0000_03E8);
		apb(0, dtfs_pkg::ADDR_DUTY, 32'h0);
		chk(rd, 32'h0000_03E8);
		for (int k = 0; k < 40; k++)
		begin
			for (int i = 0; i < 4; i++)
			begin
				cd[i] = codes[$urandom_range(0, 13)];
				if ($urandom_range(0, 1))
					cd[i] = cd[i] + 16'h0064;
				apb(1, adr[i], {16'h0000, cd[i]});
				chk(er, 0);
			end
			vf = 1'($urandom_range(0, 1));
			apb(1, dtfs_pkg::ADDR_CTRL, {31'h0, vf});
			s = dtfs_pkg::dtfs_stat_t'(21'($urandom));
			s.tune_finished = 0;
			stat <= s;
			// Thermal level sits exactly at 85 percent of trip or one step below it.
			thermal_acc <= $urandom_range(0, 1) ? 16'h0352 : 16'h0351;
			regen_duty_acc <= $urandom_range(0, 1) ? 16'h03E8 : 16'h0000;
			p = dtfs_pkg::dtfs_inp_t'(9'($urandom));
			p.tuning_request_in = 0;
			want <= p;
			repeat (8) @(posedge sys_clk);
			term = {digital_out_one, digital_out_two, digital_out_three,
				alarm_relay_terminal};
			for (int i = 0; i < 4; i++)
				chk(term[3-i], fn_val(cd[i], s, vf, thermal_acc >= 16'h0352,
					regen_duty_acc != 0, p.forward_start_in |
					p.reverse_start_in));
			chk(prop_only, p.prop_only_select_in & ~vf);
			chk(torque_bias_sel, {p.bias_select_b_in,
				p.bias_select_a_in});
			chk(control_kind, {1'b0, p.control_kind_change_in});
			chk(second_limit, p.torque_limit_level_in);
			chk(residual_flux_flag, s.residual_flux);
			chk({start_fwd, start_rev, pre_excite}, {p.forward_start_in,
				p.reverse_start_in, p.pre_excite_in});
		end
		clk_en <= 0;
		stat <= '0;
		want <= '0;
		repeat (8) @(posedge sys_clk);
		chk({digital_out_one, digital_out_two, digital_out_three,
			alarm_relay_terminal}, term);
		chk(torque_bias_sel, {p.bias_select_b_in,
			p.bias_select_a_in});
		clk_en <= 1;
		apb(1, adr[0], 32'h0000_0001);
		apb(1, adr[1], 32'h0000_0002);
		apb(1, dtfs_pkg::ADDR_CTRL, 32'h0000_0002);
		p = '0;
		p.tuning_request_in = 1;
		want <= p;
		wait_tune(1);
		s = '0;
		s.at_target_speed_status = 1;
		s.supply_fail = 1;
		stat <= s;
		p.forward_start_in = 1;
		want <= p;
		repeat (8) @(posedge sys_clk);
		chk({digital_out_one, digital_out_two}, 2'b01);
		chk(start_fwd, 0);
		s.tune_finished = 1;
		stat <= s;
		wait_tune(0);
		repeat (3) @(posedge sys_clk);
		chk({start_fwd, digital_out_one}, 2'b11);
		want <= '0;
		stat <= '0;
		repeat (10) @(posedge sys_clk);
		s = '0;
		s.residual_flux = 1;
		stat <= s;
		p = '0;
		p.tuning_request_in = 1;
		want <= p;
		repeat (12) @(posedge sys_clk);
		chk(tune_active, 0);
		chk(residual_flux_flag, 1);
		apb(1, dtfs_pkg::ADDR_CTRL, 32'h0000_0003);
		stat <= '0;
		repeat (12) @(posedge sys_clk);
		chk(tune_active, 0);
		want <= '0;
		repeat (8) @(posedge sys_clk);
		apb(1, dtfs_pkg::ADDR_CTRL, 32'h0000_0002);
		s = '0;
		s.cmd_below_start = 1;
		stat <= s;
		p = '0;
		p.pre_excite_in = 1;
		p.forward_start_in = 1;
		want <= p;
		wait_tune(1);
		chk({start_fwd, pre_excite}, 2'b00);
		apb(0, dtfs_pkg::ADDR_STATUS, 32'h0);
		chk(rd[5:4], 2'b01);
		summarize();
	end
endmodule
